// >>> design/mul_tst_pkg.sv
// Package: opcodes, addressing constants and phase encoding for the multiply/test unit
package mul_tst_pkg;
   localparam logic [7:0]  OPC_MULLIT     = 8'h0D;   // 0000_1101 kkkkkkkk
   localparam logic [6:0]  OPC_MULFILE    = 7'h01;   // 0000_001a ffffffff
   localparam logic [6:0]  OPC_TSTZ       = 7'h33;   // 0110_011a ffffffff
   localparam logic [7:0]  IDX_LIMIT      = 8'h5F;   // Indexed offset range top
   localparam logic [7:0]  ACC_SPLIT      = 8'h60;   // Access bank low/high split
   localparam logic [3:0]  ACC_HI_BANK    = 4'hF;
   localparam logic [3:0]  ACC_LO_BANK    = 4'h0;
   localparam logic [7:0]  PROD_RST       = 8'h00;
   localparam int          DADDR_W        = 12;
   typedef enum logic [1:0] {
      PH_DECODE  = 2'b00,
      PH_READ    = 2'b01,
      PH_PROCESS = 2'b10,
      PH_WRITE   = 2'b11
   } phase_t;
   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_FLUSH = 2'b01,
      ST_FLUSH2 = 2'b10
   } exec_t;
endpackage

// >>> design/multiply_and_test_skip_instr.sv
// Execution unit for literal multiply, file multiply and test-zero-skip
// Notes on behaviour
// - Literal multiply: W times 8-bit literal
// - File multiply: unsigned W times memory operand
// - 16-bit product split high/low bytes
// - W and memory operand never written
// - Multiplies leave all status flags alone
// - Zero product does not touch zero flag
// - Operand: 8-bit address plus bank selector
// - Selector 0 uses access bank
// - Selector 1 takes bank from select register
// - Extended set, selector 0, f<=95: indexed
// - Zero test discards prefetch, runs one no-op, two if next word is two-word
`timescale 1ns/10ps
module multiply_and_test_skip_instr (
   // Clock and reset
   input  wire logic                           mclk,
   input  wire logic                           sys_rst,
   // Instruction from fetch
   input  wire logic [15:0]                    instr_word,
   input  wire logic                           instr_valid,
   input  wire logic                           next_is_two_word,
   // Core state
   input  wire logic [7:0]                     w_reg,
   input  wire logic [3:0]                     bank_select_register,
   input  wire logic [mul_tst_pkg::DADDR_W-1:0] index_base,
   input  wire logic                           ext_set_en,
   // Data memory
   output logic [mul_tst_pkg::DADDR_W-1:0]     dmem_addr,
   output logic                                dmem_rd,
   input  wire logic [7:0]                     dmem_rdata,
   // Results
   output logic [7:0]                          product_high_byte,
   output logic [7:0]                          product_low_byte,
   output logic                                prod_we,
   output logic                                flush_prefetch,
   output logic                                busy,
   output mul_tst_pkg::phase_t                 phase,
   output logic                                status_we
);
   import mul_tst_pkg::*;

   phase_t              ph_r, ph_nxt;
   exec_t               st_r, st_nxt;
   logic [15:0]         ir_r, ir_nxt;
   logic                iv_r, iv_nxt;
   logic                two_r, two_nxt;
   logic [7:0]          op_r, op_nxt;
   logic [7:0]          ph_hi_r, ph_hi_nxt, pl_r, pl_nxt;
   logic                pwe_r, pwe_nxt;
   logic                fl_r, fl_nxt;
   logic [DADDR_W-1:0]  addr_r, addr_nxt;
   logic                is_mlit, is_mfile, is_tst, acc_sel;
   logic [7:0]          faddr;
   logic [15:0]         prod;

   assign is_mlit  = iv_r && (ir_r[15:8] == OPC_MULLIT) && (st_r == ST_RUN);
   assign is_mfile = iv_r && (ir_r[15:9] == OPC_MULFILE) && (st_r == ST_RUN);
   assign is_tst   = iv_r && (ir_r[15:9] == OPC_TSTZ) && (st_r == ST_RUN);
   // Operand fields come from the word being taken, so the address is ready in READ
   assign acc_sel  = instr_word[8];
   assign faddr    = instr_word[7:0];
   // Unsigned product; W is only read here
   assign prod     = is_mlit ? ({8'h00, w_reg} * {8'h00, ir_r[7:0]})
                             : ({8'h00, w_reg} * {8'h00, op_r});

   // Operand address resolution
   // Held outside decode so the read address cannot follow a later word
   always_comb begin
      addr_nxt = addr_r;
      if (ph_r == PH_DECODE) begin
         if (acc_sel) begin
            addr_nxt = {bank_select_register, faddr};
         end else if (ext_set_en && (faddr <= IDX_LIMIT)) begin
            addr_nxt = index_base + {{(DADDR_W-8){1'b0}}, faddr};
         end else if (faddr < ACC_SPLIT) begin
            addr_nxt = {ACC_LO_BANK, faddr};
         end else begin
            addr_nxt = {ACC_HI_BANK, faddr};
         end
      end
   end

   // Phase, sequence and result next-state
   always_comb begin
      ph_nxt    = phase_t'(ph_r + 2'd1);
      st_nxt    = st_r;
      ir_nxt    = ir_r;
      iv_nxt    = iv_r;
      two_nxt   = two_r;
      op_nxt    = op_r;
      ph_hi_nxt = ph_hi_r;
      pl_nxt    = pl_r;
      pwe_nxt   = 1'b0;
      fl_nxt    = 1'b0;
      case (ph_r)
         PH_DECODE: begin
            if (st_r == ST_RUN) begin
               ir_nxt  = instr_word;
               iv_nxt  = instr_valid;
               two_nxt = next_is_two_word;
            end else begin
               iv_nxt = 1'b0;
            end
         end
         PH_READ: begin
            op_nxt = dmem_rdata;
         end
         PH_PROCESS: begin
         end
         PH_WRITE: begin
            if (is_mlit || is_mfile) begin
               ph_hi_nxt = prod[15:8];
               pl_nxt    = prod[7:0];
               pwe_nxt   = 1'b1;
            end
            case (st_r)
               ST_RUN: begin
                  if (is_tst && (op_r == 8'h00)) begin
                     st_nxt = two_r ? ST_FLUSH2 : ST_FLUSH;
                     fl_nxt = 1'b1;
                  end
               end
               ST_FLUSH2: st_nxt = ST_FLUSH;
               ST_FLUSH:  st_nxt = ST_RUN;
               default:   st_nxt = ST_RUN;
            endcase
         end
         default: ph_nxt = PH_DECODE;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ph_r    <= PH_DECODE;
         st_r    <= ST_RUN;
         ir_r    <= 16'h0000;
         iv_r    <= 1'b0;
         two_r   <= 1'b0;
         op_r    <= 8'h00;
         ph_hi_r <= PROD_RST;
         pl_r    <= PROD_RST;
         pwe_r   <= 1'b0;
         fl_r    <= 1'b0;
         addr_r  <= '0;
      end else begin
         ph_r    <= ph_nxt;
         st_r    <= st_nxt;
         ir_r    <= ir_nxt;
         iv_r    <= iv_nxt;
         two_r   <= two_nxt;
         op_r    <= op_nxt;
         ph_hi_r <= ph_hi_nxt;
         pl_r    <= pl_nxt;
         pwe_r   <= pwe_nxt;
         fl_r    <= fl_nxt;
         addr_r  <= addr_nxt;
      end
   end

   assign dmem_addr         = addr_r;
   // Read only in the read phase; no write strobe exists, so memory is never modified
   assign dmem_rd           = (ph_r == PH_READ) && (is_mfile || is_tst);
   assign product_high_byte = ph_hi_r;
   assign product_low_byte  = pl_r;
   assign prod_we           = pwe_r;
   assign flush_prefetch    = fl_r;
   assign busy              = (st_r != ST_RUN);
   assign phase             = ph_r;
   // None of these instructions updates flags, zero product included
   assign status_we         = 1'b0;

   // Assertions
   product_value_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE && is_mlit) |=>
      ({ph_hi_r, pl_r} == {8'h00, $past(w_reg)} * {8'h00, $past(ir_r[7:0])}))
      else $error("literal product wrong");

   lit_no_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_READ && is_mlit) |-> !dmem_rd)
      else $error("literal multiply read memory");

   file_product_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE && is_mfile) |=>
      ({ph_hi_r, pl_r} == {8'h00, $past(w_reg)} * {8'h00, $past(op_r)}))
      else $error("file product wrong");

   file_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_READ && is_mfile) |-> dmem_rd)
      else $error("file operand not read");

   op_capture_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_READ && dmem_rd) |=> op_r == $past(dmem_rdata))
      else $error("operand not captured");

   split_bytes_a: assert property (@(posedge mclk) disable iff (sys_rst)
      pwe_r |-> (ph_hi_r == $past(prod[15:8]) && pl_r == $past(prod[7:0])))
      else $error("product bytes misplaced");

   prod_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
      prod_we |=> !prod_we)
      else $error("product strobe too long");

   hold_prod_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !pwe_r |-> $stable(ph_hi_r) && $stable(pl_r))
      else $error("product changed without write");

   prod_only_mul_a: assert property (@(posedge mclk) disable iff (sys_rst)
      prod_we |-> $past(is_mlit || is_mfile))
      else $error("product written by other op");

   tst_no_prod_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE && is_tst) |=> !prod_we && $stable(product_low_byte))
      else $error("test wrote product");

   no_flags_a: assert property (@(posedge mclk) disable iff (sys_rst) !status_we)
      else $error("status written");

   zero_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (pwe_r && {ph_hi_r, pl_r} == 16'h0000) |-> !status_we)
      else $error("zero product flagged");

   addr_stable_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r != PH_DECODE) |=> $stable(addr_r))
      else $error("operand address moved");

   access_low_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_DECODE && !acc_sel && !ext_set_en && faddr < ACC_SPLIT) |=>
      addr_r == {ACC_LO_BANK, $past(faddr)})
      else $error("low access address wrong");

   access_high_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_DECODE && !acc_sel && faddr >= ACC_SPLIT) |=>
      addr_r == {ACC_HI_BANK, $past(faddr)})
      else $error("high access address wrong");

   bank_addr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_DECODE && acc_sel) |=>
      addr_r == {$past(bank_select_register), $past(faddr)})
      else $error("bank address wrong");

   indexed_addr_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_DECODE && !acc_sel && ext_set_en && faddr <= IDX_LIMIT) |=>
      addr_r == $past(index_base) + {{(DADDR_W-8){1'b0}}, $past(faddr)})
      else $error("indexed address wrong");

   skip_flush_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE && is_tst && op_r == 8'h00 && !two_r) |=>
      (fl_r && busy) ##1 busy [*3] ##1 !busy)
      else $error("skip missing");

   flush_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
      fl_r |=> !fl_r)
      else $error("flush strobe too long");

   busy_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(busy) |-> fl_r)
      else $error("busy without flush");

   refuse_busy_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (busy && ph_r == PH_DECODE) |=> !iv_r)
      else $error("word taken while flushing");

   skip_nop_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (busy && ph_r == PH_WRITE) |=> !prod_we && !fl_r)
      else $error("flushed cycle did work");

   phase_cycle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_DECODE) |=> ph_r == PH_READ ##1 ph_r == PH_PROCESS ##1 ph_r == PH_WRITE)
      else $error("phase order broken");

   phase_wrap_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE) |=> ph_r == PH_DECODE)
      else $error("phase did not wrap");

   rd_phase_a: assert property (@(posedge mclk) disable iff (sys_rst)
      dmem_rd |-> ph_r == PH_READ)
      else $error("read outside read phase");

   decode_take_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_DECODE && !busy) |=> ir_r == $past(instr_word))
      else $error("instruction not taken");

   noskip_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE && is_tst && op_r != 8'h00) |=> !fl_r && !busy)
      else $error("nonzero test skipped");

   lit_one_cycle_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE && (is_mlit || is_mfile)) |=> !busy)
      else $error("multiply took extra cycle");

   two_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE && is_tst && op_r == 8'h00 && two_r) |=> st_r == ST_FLUSH2)
      else $error("two-word skip not entered");

   two_state_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (st_r == ST_FLUSH2 && ph_r == PH_WRITE) |=> st_r == ST_FLUSH)
      else $error("second no-op missing");

   two_flush_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ph_r == PH_WRITE && is_tst && op_r == 8'h00 && two_r) |=> busy [*8] ##1 !busy)
      else $error("two-word skip short");

   cov_mlit: cover property (@(posedge mclk) disable iff (sys_rst) is_mlit && pwe_nxt);
   cov_mfile: cover property (@(posedge mclk) disable iff (sys_rst) is_mfile && pwe_nxt);
   cov_skip: cover property (@(posedge mclk) disable iff (sys_rst) fl_r && st_r == ST_FLUSH);
   cov_skip2: cover property (@(posedge mclk) disable iff (sys_rst) st_r == ST_FLUSH2);
   cov_noskip: cover property (@(posedge mclk) disable iff (sys_rst)
      ph_r == PH_WRITE && is_tst && op_r != 8'h00);
endmodule

// >>> dv/dmem_model.sv
// Data memory model answering the execution unit's operand reads
`timescale 1ns/10ps
module dmem_model (
   // Clock
   input  wire logic        mclk,
   // Read port
   input  wire logic [11:0] dmem_addr,
   input  wire logic        dmem_rd,
   output logic      [7:0]  dmem_rdata
);
   logic [7:0] mem [4096];
   logic [7:0] last_r = 8'h00;
   // Unread cycles show the inverse of the last value, so a stale sample is caught
   always @(posedge mclk) begin
      if (dmem_rd) begin
         last_r <= mem[dmem_addr];
      end
   end
   assign dmem_rdata = dmem_rd ? mem[dmem_addr] : ~last_r;
endmodule

// >>> dv/multiply_and_test_skip_instr_tb.sv
// Self-checking bench for the multiply and test-zero-skip unit
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module multiply_and_test_skip_instr_tb;
   import mul_tst_pkg::*;
   logic        mclk = 0, sys_rst = 1, instr_valid = 0, next_is_two_word = 0, ext_set_en = 0;
   logic [15:0] instr_word = 16'h0000;
   logic [7:0]  w_reg = 8'h00, dmem_rdata, product_high_byte, product_low_byte;
   logic [3:0]  bank_select_register = 4'h0;
   logic [11:0] index_base = 12'h000, dmem_addr;
   logic        dmem_rd, prod_we, flush_prefetch, busy, status_we;
   phase_t      phase;
   int          fail_count = 0, total_checks = 0;
   always #25 mclk = ~mclk;
   multiply_and_test_skip_instr i_multiply_and_test_skip_instr (.mclk(mclk), .sys_rst(sys_rst),
      .instr_word(instr_word), .instr_valid(instr_valid), .next_is_two_word(next_is_two_word),
      .w_reg(w_reg), .bank_select_register(bank_select_register), .index_base(index_base),
      .ext_set_en(ext_set_en), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
      .dmem_rdata(dmem_rdata), .product_high_byte(product_high_byte),
      .product_low_byte(product_low_byte), .prod_we(prod_we), .flush_prefetch(flush_prefetch),
      .busy(busy), .phase(phase), .status_we(status_we));
   dmem_model i_dmem_model (.mclk(mclk), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
      .dmem_rdata(dmem_rdata));
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // One instruction cycle, then the flushed cycles that follow it
   task automatic run(input logic [15:0] iw, input logic two, input logic [11:0] ea,
                      input logic [15:0] ep, input logic pw, input int nb);
      int k;
      for (k = 0; k < 8 && !(phase === PH_DECODE && busy === 1'b0); k++) @(posedge mclk) #2;
      if (k == 8) begin
         fail_count++;
         tally_and_finish();
      end
      instr_word = iw;
      instr_valid = 1;
      next_is_two_word = two;
      @(posedge mclk) #2;
      instr_valid = 0;
      `CHK("rd", iw[15:8] !== OPC_MULLIT, dmem_rd)
      if (dmem_rd === 1'b1) `CHK("addr", ea, dmem_addr)
      repeat (3) @(posedge mclk) #2;
      `CHK("pwe", pw, prod_we)
      `CHK("flush", nb > 0, flush_prefetch)
      `CHK("prod", ep, {product_high_byte, product_low_byte})
      `CHK("stat", 1'b0, status_we)
      for (k = 0; k < 12 && busy === 1'b1; k++) @(posedge mclk) #2;
      `CHK("busy", nb, k)
   endtask
   task automatic fm(input logic a, input logic [7:0] f, input logic [11:0] ea,
                     input logic [7:0] m);
      i_dmem_model.mem[ea] = m;
      run({OPC_MULFILE, a, f}, 1'b0, ea, {8'h00, w_reg} * {8'h00, m}, 1'b1, 0);
   endtask
   task automatic t_lit();
      w_reg = 8'hE2;
      run({OPC_MULLIT, 8'hC4}, 1'b0, 12'h000, 16'hAD08, 1'b1, 0);
      w_reg = 8'hFF;
      run({OPC_MULLIT, 8'hFF}, 1'b0, 12'h000, 16'hFE01, 1'b1, 0);
      run({OPC_MULLIT, 8'h00}, 1'b0, 12'h000, 16'h0000, 1'b1, 0);
      $display("literal multiply finished");
   endtask
   task automatic t_file();
      w_reg = 8'hFF;
      fm(1'b0, 8'h20, 12'h020, 8'hFF);
      w_reg = 8'h30;
      fm(1'b0, 8'h80, 12'hF80, 8'h07);
      bank_select_register = 4'h5;
      fm(1'b1, 8'h20, 12'h520, 8'h03);
      ext_set_en = 1;
      index_base = 12'h300;
      fm(1'b0, 8'h5F, 12'h35F, 8'h02);
      fm(1'b0, 8'h60, 12'hF60, 8'h01);
      ext_set_en = 0;
      $display("file multiply finished");
   endtask
   task automatic t_skip();
      i_dmem_model.mem[12'h021] = 8'h5A;
      run({OPC_TSTZ, 1'b0, 8'h21}, 1'b0, 12'h021, 16'h0030, 1'b0, 0);
      i_dmem_model.mem[12'h021] = 8'h00;
      run({OPC_TSTZ, 1'b0, 8'h21}, 1'b0, 12'h021, 16'h0030, 1'b0, 4);
      run({OPC_TSTZ, 1'b0, 8'h21}, 1'b1, 12'h021, 16'h0030, 1'b0, 8);
      i_dmem_model.mem[12'h521] = 8'h00;
      run({OPC_TSTZ, 1'b1, 8'h21}, 1'b0, 12'h521, 16'h0030, 1'b0, 4);
      $display("test and skip finished");
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      #2 sys_rst = 0;
      t_lit();
      t_file();
      t_skip();
      tally_and_finish();
   end
endmodule
